// ==== rtl/sop_pkg.sv ====
package sop_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] SOP_OFF_CTRL = 8'h00;
    localparam logic [7:0] SOP_OFF_LEFT = 8'h04;
    localparam logic [7:0] SOP_OFF_RIGHT = 8'h08;
    localparam logic [7:0] SOP_OFF_STATUS = 8'h0C;
    localparam int SOP_CTRL_EN_BIT = 0;
    localparam int SOP_CTRL_W18_BIT = 1;
    localparam logic [1:0] SOP_CTRL_RST = 2'h3;
    localparam logic [17:0] SOP_SAMPLE_RST = 18'h0_0000;
    localparam logic [1:0] SOP_RESP_OKAY = 2'h0;
    localparam logic [1:0] SOP_RESP_DECERR = 2'h3;

    // ------------------------------------------------------------
    // Frame geometry and timing
    // ------------------------------------------------------------
    localparam int SOP_SAMPLE_W = 18;
    localparam logic [4:0] SOP_LIMIT_18 = 5'h0E;
    localparam logic [4:0] SOP_LIMIT_16 = 5'h10;
    localparam logic [4:0] SOP_LAST_WIDE = 5'h1F;
    localparam logic [4:0] SOP_LAST_NARROW = 5'h0F;
    localparam logic [2:0] SOP_HALF_WIDE = 3'h2;
    localparam logic [2:0] SOP_HALF_NARROW = 3'h4;
endpackage : sop_pkg

// ==== rtl/sop_sync3.sv ====
`timescale 1ns/1ps
module sop_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } sop_sync_t;

    sop_sync_t st_reg;
    sop_sync_t st_next;

    // A level counts only once stages two and three agree
    always_comb begin
        st_next = st_reg;
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.q[i] = st_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.q;
endmodule : sop_sync3

// ==== rtl/sop_div.sv ====
`timescale 1ns/1ps
module sop_div (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic clr_in,
    input wire logic [2:0] half_in,
    output logic tick_out
);
    typedef struct packed {
        logic [2:0] cnt;
        logic tick;
    } sop_div_t;

    sop_div_t st_reg;
    sop_div_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (clr_in) begin
            st_next.cnt = 3'h0;
        end else if (st_reg.cnt == half_in - 3'h1) begin
            st_next.cnt = 3'h0;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 3'h1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick_out = st_reg.tick;
endmodule : sop_div

// ==== rtl/sop_port.sv ====
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module sop_port
    import sop_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic frame_select_in,
    input wire logic mode_select_low_in,
    input wire logic mode_select_high_in,
    input wire logic serial_bit_clock_in,
    output logic serial_bit_clock_out,
    output logic serial_bit_clock_oe_out,
    input wire logic word_strobe_in,
    output logic word_strobe_out,
    output logic word_strobe_oe_out,
    input wire logic channel_select_clock_in,
    output logic channel_select_clock_out,
    output logic channel_select_clock_oe_out,
    output logic serial_data_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic wide;
        logic master;
        logic drv;
        logic slave;
        logic rsvd;
        logic serial_bit_clock;
        logic channel_select_clock;
        logic word_strobe;
        logic dat;
        logic bck_oe;
        logic channel_select_clock_oe;
        logic wck_oe;
        logic bck_seen;
        logic channel_select_clock_seen;
        logic [4:0] cnt;
        logic started;
        logic ok;
        logic first_done;
        logic chan_left;
        logic shift_pend;
        logic [17:0] shreg;
        logic [15:0] words;
        logic [1:0] ctrl;
        logic [17:0] left;
        logic [17:0] right;
        logic aw_rdy;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_rdy;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sop_state_t;

    sop_state_t st_reg;
    sop_state_t st_next;

    logic [5:0] pins_f;
    logic fs_f, sl_f, sh_f, bck_f, wck_f, channel_select_clock_f;
    logic tick, run, fall, field_start, start, chan_new;
    logic [4:0] cnt_new;
    logic [4:0] limit;
    logic [17:0] word;

    // ------------------------------------------------------------
    // Pin retiming and bit clock divider
    // ------------------------------------------------------------
    // Every pin input is retimed, so slave clocks must be slow enough
    sop_sync3 #(.WIDTH(6)) u_sync (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .async_in({frame_select_in, mode_select_low_in, mode_select_high_in,
                   serial_bit_clock_in, word_strobe_in, channel_select_clock_in}),
        .level_out(pins_f)
    );
    assign {fs_f, sl_f, sh_f, bck_f, wck_f, channel_select_clock_f} = pins_f;

    sop_div u_div (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .clr_in(!run || !st_reg.master),
        .half_in(st_reg.wide ? SOP_HALF_WIDE : SOP_HALF_NARROW),
        .tick_out(tick)
    );

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic [31:0] rd_mux(input sop_state_t s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            SOP_OFF_CTRL: r = {30'h0000_0000, s.ctrl};
            SOP_OFF_LEFT: r = {14'h0000, s.left};
            SOP_OFF_RIGHT: r = {14'h0000, s.right};
            SOP_OFF_STATUS: r = {s.words, 11'h000, s.chan_left, s.rsvd, s.slave,
                                 s.master, s.wide};
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction : rd_mux

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] m;
        m = 32'h0000_0000;
        st_next = st_reg;
        fall = 1'b0;
        field_start = 1'b0;
        start = 1'b0;
        cnt_new = st_reg.cnt;
        chan_new = st_reg.chan_left;
        word = 18'h0_0000;

        // Static mode pins decoded every cycle
        st_next.wide = fs_f;
        st_next.master = !sh_f;
        st_next.drv = !sl_f && !sh_f;
        st_next.slave = sl_f && sh_f;
        st_next.rsvd = !sl_f && sh_f;
        run = st_reg.ctrl[SOP_CTRL_EN_BIT] && !st_reg.rsvd;
        limit = st_reg.ctrl[SOP_CTRL_W18_BIT] ? SOP_LIMIT_18 : SOP_LIMIT_16;

        st_next.bck_oe = st_reg.master && !st_reg.rsvd;
        st_next.channel_select_clock_oe = st_reg.master && !st_reg.rsvd;
        st_next.wck_oe = st_reg.drv;
        st_next.bck_seen = bck_f;
        st_next.shift_pend = 1'b0;

        if (st_reg.shift_pend) begin
            st_next.dat = st_reg.shreg[17];
            st_next.shreg = {st_reg.shreg[16:0], 1'b0};
        end

        if (!run) begin
            // Idle restarts on a left field once enabled
            st_next.serial_bit_clock = 1'b0;
            st_next.channel_select_clock = 1'b0;
            st_next.word_strobe = st_reg.drv && !st_reg.wide;
            st_next.dat = 1'b0;
            st_next.shreg = 18'h0_0000;
            st_next.cnt = st_reg.wide ? SOP_LAST_WIDE : SOP_LAST_NARROW;
            st_next.started = 1'b0;
            st_next.ok = 1'b0;
            st_next.first_done = 1'b0;
            st_next.channel_select_clock_seen = channel_select_clock_f;
        end else begin
            if (st_reg.master) begin
                if (tick) begin
                    st_next.serial_bit_clock = !st_reg.serial_bit_clock;
                    fall = st_reg.serial_bit_clock;
                end
                field_start = fall &&
                    (st_reg.cnt == (st_reg.wide ? SOP_LAST_WIDE : SOP_LAST_NARROW));
            end else begin
                // Slave follows the same sequence as strobe-input master
                fall = st_reg.bck_seen && !bck_f;
                field_start = fall && (channel_select_clock_f != st_reg.channel_select_clock_seen);
            end
            if (st_reg.drv && !st_reg.wide) begin
                st_next.word_strobe = 1'b1;
            end
            if (fall) begin
                cnt_new = field_start ? 5'h00 : st_reg.cnt + 5'h01;
                st_next.cnt = cnt_new;
                if (field_start) begin
                    chan_new = st_reg.master ? !st_reg.channel_select_clock : channel_select_clock_f;
                    st_next.chan_left = chan_new;
                    st_next.channel_select_clock = st_reg.master ? !st_reg.channel_select_clock : st_reg.channel_select_clock;
                    st_next.channel_select_clock_seen = channel_select_clock_f;
                    st_next.started = 1'b0;
                    st_next.ok = chan_new || st_reg.first_done;
                    st_next.first_done = st_reg.first_done || chan_new;
                    start = (chan_new || st_reg.first_done) && !st_reg.wide;
                end else if (st_reg.wide && st_reg.ok && !st_reg.started) begin
                    // Each field searches for its own strobe
                    if (st_reg.drv) begin
                        start = (cnt_new == limit);
                    end else begin
                        start = wck_f || (cnt_new == limit);
                    end
                end
                word = chan_new ? st_reg.left : st_reg.right;
                if (!st_reg.ctrl[SOP_CTRL_W18_BIT]) begin
                    word = {word[15:0], 2'b00};
                end else if (!st_reg.wide) begin
                    word = {word[17:2], 2'b00};
                end
                if (start) begin
                    // MSB leaves with the edge, later bits one cycle after
                    st_next.dat = word[17];
                    st_next.shreg = {word[16:0], 1'b0};
                    st_next.started = 1'b1;
                    st_next.words = st_reg.words + 16'h0001;
                    if (st_reg.drv && st_reg.wide) begin
                        st_next.word_strobe = 1'b1;
                    end
                end else begin
                    st_next.shift_pend = 1'b1;
                    if (st_reg.drv && st_reg.wide) begin
                        st_next.word_strobe = 1'b0;
                    end
                end
            end
        end

        // AXI4-Lite write: address and data in either order
        if (s_axi_awvalid_in && st_reg.aw_rdy) begin
            st_next.aw_got = 1'b1;
            st_next.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && st_reg.w_rdy) begin
            st_next.w_got = 1'b1;
            st_next.w_data = s_axi_wdata_in;
            st_next.w_strb = s_axi_wstrb_in;
        end
        if (s_axi_bready_in && st_reg.bvalid) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = SOP_RESP_OKAY;
            m = merge(rd_mux(st_reg, st_reg.aw_addr), st_reg.w_data, st_reg.w_strb);
            case (st_reg.aw_addr)
                SOP_OFF_CTRL: st_next.ctrl = m[1:0];
                SOP_OFF_LEFT: st_next.left = m[17:0];
                SOP_OFF_RIGHT: st_next.right = m[17:0];
                SOP_OFF_STATUS: st_next.bresp = SOP_RESP_OKAY;
                default: st_next.bresp = SOP_RESP_DECERR;
            endcase
        end
        st_next.aw_rdy = !st_next.aw_got && !st_next.bvalid;
        st_next.w_rdy = !st_next.w_got && !st_next.bvalid;

        // AXI4-Lite read
        if (s_axi_rready_in && st_reg.rvalid) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && st_reg.ar_rdy) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = rd_mux(st_reg, s_axi_araddr_in);
            case (s_axi_araddr_in)
                SOP_OFF_CTRL, SOP_OFF_LEFT, SOP_OFF_RIGHT, SOP_OFF_STATUS:
                    st_next.rresp = SOP_RESP_OKAY;
                default: st_next.rresp = SOP_RESP_DECERR;
            endcase
        end
        st_next.ar_rdy = !st_next.rvalid;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
            st_reg.ctrl <= SOP_CTRL_RST;
            st_reg.left <= SOP_SAMPLE_RST;
            st_reg.right <= SOP_SAMPLE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready_out = st_reg.aw_rdy;
    assign s_axi_wready_out = st_reg.w_rdy;
    assign s_axi_bresp_out = st_reg.bresp;
    assign s_axi_bvalid_out = st_reg.bvalid;
    assign s_axi_arready_out = st_reg.ar_rdy;
    assign s_axi_rdata_out = st_reg.rdata;
    assign s_axi_rresp_out = st_reg.rresp;
    assign s_axi_rvalid_out = st_reg.rvalid;
    assign serial_bit_clock_out = st_reg.serial_bit_clock;
    assign serial_bit_clock_oe_out = st_reg.bck_oe;
    assign word_strobe_out = st_reg.word_strobe;
    assign word_strobe_oe_out = st_reg.wck_oe;
    assign channel_select_clock_out = st_reg.channel_select_clock;
    assign channel_select_clock_oe_out = st_reg.channel_select_clock_oe;
    assign serial_data_out = st_reg.dat;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    sequence wide_master_s;
        st_reg.wide && st_reg.master && !st_reg.rsvd;
    endsequence

    sequence narrow_master_s;
        !st_reg.wide && st_reg.master && !st_reg.rsvd;
    endsequence

    wide_bck_period_a: assert property (
        disable iff (!rst_n_in || !run)
        ($rose(serial_bit_clock_out) ##0 wide_master_s) |=>
            (!$rose(serial_bit_clock_out))[*3] ##1 $rose(serial_bit_clock_out))
        else $error("wide bit clock not master clock over four");

    narrow_bck_period_a: assert property (
        disable iff (!rst_n_in || !run)
        ($rose(serial_bit_clock_out) ##0 narrow_master_s) |=>
            (!$rose(serial_bit_clock_out))[*7] ##1 $rose(serial_bit_clock_out))
        else $error("narrow bit clock not master clock over eight");

    strobe_high_a: assert property (
        (st_reg.drv && !st_reg.wide)[*3] |-> word_strobe_out && word_strobe_oe_out)
        else $error("narrow driven strobe not held high");

    strobe_float_a: assert property (
        (st_reg.master && !st_reg.drv && !st_reg.wide)[*3] |-> !word_strobe_oe_out)
        else $error("ignored strobe pin is driven");

    master_clocks_out_a: assert property (
        (st_reg.master && !st_reg.rsvd)[*2] |-> serial_bit_clock_oe_out &&
            channel_select_clock_oe_out)
        else $error("master mode clocks not driven");

    slave_clocks_in_a: assert property (
        st_reg.slave[*2] |-> !serial_bit_clock_oe_out && !channel_select_clock_oe_out)
        else $error("slave mode drives channel clock");

    msb_first_a: assert property (
        start |=> serial_data_out == $past(word[17]))
        else $error("word not started with its top bit");

    late_strobe_a: assert property (
        (fall && st_reg.wide && st_reg.ok && !st_reg.started && !field_start &&
         cnt_new == limit) |-> start ##1 st_reg.started)
        else $error("word not forced at the limit bit");

    left_first_a: assert property (
        (start && !st_reg.first_done) |-> chan_new)
        else $error("first word after reset is not left");

    strobe_leads_msb_a: assert property (
        (start && st_reg.drv && st_reg.wide) |=> word_strobe_out ##1
            (word_strobe_out throughout !st_reg.serial_bit_clock[*1]))
        else $error("driven strobe not raised with the top bit");
endmodule : sop_port

// ==== bench/sop_rx_model.sv ====
`timescale 1ns/1ps
module sop_rx_model (
    input wire logic bit_clock_in,
    input wire logic chan_clock_in,
    input wire logic data_in,
    output logic [31:0] word_out,
    output logic left_out,
    output int count_out,
    output int period_out
);
    logic [31:0] shift_reg = 32'h0000_0000;
    realtime last_rise = 0.0;
    initial begin
        word_out = 32'h0000_0000;
        left_out = 1'b0;
        count_out = 0;
        period_out = 0;
    end
    // Sample on bit clock rise, data settled since the fall
    always @(posedge bit_clock_in) begin
        shift_reg = {shift_reg[30:0], data_in};
        period_out = int'($realtime - last_rise);
        last_rise = $realtime;
    end
    // Level before the turn names the field that just ended
    always @(chan_clock_in) begin
        word_out = shift_reg;
        left_out = !chan_clock_in;
        count_out = count_out + 1;
    end
endmodule : sop_rx_model

// ==== bench/test_sop_port.sv ====
`timescale 1ns/1ps
module test_sop_port
    import sop_pkg::*;
;
    localparam logic [17:0] LEFT_S = 18'h2_0001;
    localparam logic [17:0] RIGHT_S = 18'h1_FFFE;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic fs = 1'b1, sel_lo = 1'b0, sel_hi = 1'b0, strobe = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, rx_left;
    logic serial_bit_clock, bck_oe, ws, ws_oe, channel_select_clock, channel_select_clock_oe, sdata;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rx_word;
    int rx_count, rx_period, failures = 0, checks = 0;
    logic slave_sel = 1'b0;
    logic [9:0] sl_cnt = 10'h000;
    logic sl_bck, sl_channel_select_clock;
    always #5 clk_sys_in = ~clk_sys_in;
    // Far-side timing source: 160 ns bit clock, channel turns on its fall
    always @(posedge clk_sys_in) begin
        if (!slave_sel) begin
            sl_cnt <= 10'h000;
        end else begin
            sl_cnt <= sl_cnt + 10'h001;
        end
    end
    assign sl_bck = sl_cnt[3];
    assign sl_channel_select_clock = sl_cnt[9];
    sop_port u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .frame_select_in(fs),
        .mode_select_low_in(sel_lo), .mode_select_high_in(sel_hi),
        .serial_bit_clock_in(sl_bck), .serial_bit_clock_out(serial_bit_clock),
        .serial_bit_clock_oe_out(bck_oe),
        .word_strobe_in(strobe), .word_strobe_out(ws), .word_strobe_oe_out(ws_oe),
        .channel_select_clock_in(sl_channel_select_clock), .channel_select_clock_out(channel_select_clock),
        .channel_select_clock_oe_out(channel_select_clock_oe), .serial_data_out(sdata));
    sop_rx_model u_rx (.bit_clock_in(bck_oe ? serial_bit_clock : sl_bck),
        .chan_clock_in(channel_select_clock_oe ? channel_select_clock : sl_channel_select_clock), .data_in(sdata),
        .word_out(rx_word), .left_out(rx_left), .count_out(rx_count), .period_out(rx_period));
    // ------------------------------------------------------------
    // Compare and bus tasks
    // ------------------------------------------------------------
    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_data
    task automatic chk_pin(input logic got, input logic exp, input string what);
        chk_data({31'h0000_0000, got}, {31'h0000_0000, exp}, what);
    endtask : chk_pin
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 200) begin
            @(posedge clk_sys_in);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                chk_data({30'h0000_0000, bresp}, {30'h0000_0000, er}, "bresp");
                n = 1000;
            end
        end
        if (n != 1000) chk_data(32'h0000_0000, 32'h0000_0001, "write hang");
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 200) begin
            @(posedge clk_sys_in);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                chk_data(rdata, ed, "rdata");
                chk_data({30'h0000_0000, rresp}, {30'h0000_0000, er}, "rresp");
                n = 1000;
            end
        end
        if (n != 1000) chk_data(32'h0000_0000, 32'h0000_0001, "read hang");
    endtask : axi_read
    task automatic next_field;
        int c, n;
        c = rx_count;
        n = 0;
        while (rx_count == c && n < 5000) begin
            @(posedge clk_sys_in);
            n++;
        end
        if (n >= 5000) chk_data(32'h0000_0000, 32'h0000_0001, "no field");
    endtask : next_field
    function automatic logic [31:0] exp_field(input int kind, input logic [17:0] s);
        case (kind)
            0: exp_field = {14'h0000, s};
            1: exp_field = {16'h0000, s[15:0]};
            2: exp_field = {16'h0000, s[17:2]};
            default: exp_field = {1'b0, s, 13'h0000};
        endcase
    endfunction : exp_field
    // Narrow fields hold only 16 fresh bits, so the rest is masked
    task automatic run_mode(input logic f, input logic lo, input logic [31:0] ctrl,
                            input int kind, input string name);
        logic [31:0] mask;
        mask = (kind == 2) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
        axi_write(SOP_OFF_CTRL, 32'h0000_0000, SOP_RESP_OKAY);
        fs <= f;
        sel_lo <= lo;
        sel_hi <= slave_sel;
        repeat (12) @(posedge clk_sys_in);
        axi_write(SOP_OFF_CTRL, ctrl, SOP_RESP_OKAY);
        next_field();
        next_field();
        chk_pin(rx_left, 1'b1, "first field left");
        chk_data(rx_word & mask, exp_field(kind, LEFT_S), "left word");
        next_field();
        chk_pin(rx_left, 1'b0, "second field right");
        chk_data(rx_word & mask, exp_field(kind, RIGHT_S), "right word");
        chk_data(32'(rx_period), slave_sel ? 32'h0000_00A0 :
                 ((kind == 2) ? 32'h0000_0050 : 32'h0000_0028), "bit");
        chk_pin(bck_oe, !slave_sel, "bit clock oe");
        chk_pin(channel_select_clock_oe, !slave_sel, "chan clock oe");
        $display("test %s done", name);
    endtask : run_mode
    task automatic print_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        axi_read(SOP_OFF_CTRL, {30'h0000_0000, SOP_CTRL_RST}, SOP_RESP_OKAY);
        axi_read(SOP_OFF_LEFT, 32'h0000_0000, SOP_RESP_OKAY);
        axi_read(8'h10, 32'h0000_0000, SOP_RESP_DECERR);
        axi_write(8'h14, 32'h0000_0001, SOP_RESP_DECERR);
        axi_write(SOP_OFF_LEFT, 32'hFFFE_0001, SOP_RESP_OKAY);
        axi_write(SOP_OFF_RIGHT, {14'h0000, RIGHT_S}, SOP_RESP_OKAY);
        axi_read(SOP_OFF_LEFT, {14'h0000, LEFT_S}, SOP_RESP_OKAY);
        $display("test registers done");
        run_mode(1'b1, 1'b0, 32'h0000_0003, 0, "wide driven 18");
        chk_pin(ws_oe, 1'b1, "strobe oe driven");
        run_mode(1'b1, 1'b0, 32'h0000_0001, 1, "wide driven 16");
        run_mode(1'b1, 1'b1, 32'h0000_0003, 0, "strobe late 18");
        run_mode(1'b1, 1'b1, 32'h0000_0001, 1, "strobe late 16");
        strobe <= 1'b1;
        run_mode(1'b1, 1'b1, 32'h0000_0003, 3, "strobe first bit");
        run_mode(1'b0, 1'b0, 32'h0000_0003, 2, "narrow driven");
        chk_pin(ws, 1'b1, "strobe held high");
        run_mode(1'b0, 1'b1, 32'h0000_0003, 2, "narrow ignore");
        chk_pin(ws_oe, 1'b0, "strobe floats");
        slave_sel <= 1'b1;
        run_mode(1'b1, 1'b1, 32'h0000_0003, 3, "slave wide");
        fs <= 1'b1;
        sel_lo <= 1'b0;
        sel_hi <= 1'b1;
        repeat (12) @(posedge clk_sys_in);
        chk_pin(bck_oe | ws_oe | channel_select_clock_oe, 1'b0, "reserved idle");
        $display("test reserved done");
        print_verdict();
    end
    initial begin
        #300000;
        failures++;
        $display("FAIL t=%0t watchdog", $time);
        print_verdict();
    end
endmodule : test_sop_port
